// ---- logic/ums_pkg.sv ----
// constants, register map and field positions of the modem status block
// assumes a 32-bit AXI4-Lite master and a 200 MHz aclk
package ums_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_HOLDING = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_IER = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_ISR_FCR = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_LCR = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_MCR = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_LSR = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_MSR = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_SCRATCH = 8'h1C;
	localparam logic [ADDR_W-1:0] ADDR_DIV_LOW = 8'h20;
	localparam logic [ADDR_W-1:0] ADDR_DIV_HIGH = 8'h24;
	localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS = 8'h28;
	localparam logic [ADDR_W-1:0] ADDR_EVT_CLEAR = 8'h2C;
	localparam logic [ADDR_W-1:0] ADDR_EVT_ENABLE = 8'h30;

	localparam logic [7:0] RST_IER = 8'h00;
	localparam logic [7:0] RST_FCR = 8'h00;
	localparam logic [7:0] RST_LCR = 8'h00;
	localparam logic [7:0] RST_MCR = 8'h00;
	localparam logic [7:0] RST_SCRATCH = 8'hFF;
	localparam logic [7:0] RST_DIV = 8'h01;
	localparam logic [7:0] ISR_NONE = 8'h01;
	localparam logic [7:0] ISR_MODEM = 8'h00;
	localparam logic [7:0] ISR_TX = 8'h02;
	localparam logic [7:0] ISR_RX = 8'h04;

	// modem control fields
	localparam int unsigned MCR_DTR = 0;
	localparam int unsigned MCR_RTS = 1;
	localparam int unsigned MCR_OP1 = 2;
	localparam int unsigned MCR_OP2 = 3;
	localparam int unsigned MCR_LOOP = 4;
	localparam int unsigned MCR_PWRDN = 7;
	// interrupt enable fields
	localparam int unsigned IER_RX = 0;
	localparam int unsigned IER_TX = 1;
	localparam int unsigned IER_MODEM = 3;
	localparam int unsigned IER_EXT = 5;
	// line control / line status fields
	localparam int unsigned LCR_BREAK = 6;
	localparam int unsigned LSR_DR = 0;
	localparam int unsigned LSR_THRE = 5;
	localparam int unsigned LSR_TEMT = 6;
	// modem input order inside the 4-bit groups: cts, dsr, ri, cd
	localparam int unsigned MI_CTS = 0;
	localparam int unsigned MI_DSR = 1;
	localparam int unsigned MI_RI = 2;
	localparam int unsigned MI_CD = 3;
	// sticky event bits
	localparam int unsigned EVT_W = 3;
	localparam int unsigned EVT_MODEM = 0;
	localparam int unsigned EVT_RX = 1;
	localparam int unsigned EVT_TX = 2;

	// timing in baud-clock periods (16x data rate)
	localparam int unsigned RX_FLAG_BCLK = 1;
	localparam int unsigned TX_START_MIN_BCLK = 8;
	localparam int unsigned TX_START_MAX_BCLK = 24;
	localparam int unsigned TX_START_BCLK =
		(TX_START_MIN_BCLK + TX_START_MAX_BCLK) / 2;
	localparam int unsigned START_CENTER_BCLK = 8;
	localparam int unsigned TX_READY_MAX_BCLK = 8;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- logic/ums_baud_if.sv ----
// signals between the register core and the baud-clock timer
// assumes both ends run on the same aclk
`timescale 1ns/1ps
interface ums_baud_if;
	logic [15:0] divisor;
	logic rx_stop;
	logic tx_kick;
	logic rx_event;
	logic tx_start;
	logic tx_ready_set;
	modport core (output divisor, output rx_stop, output tx_kick,
		input rx_event, input tx_start, input tx_ready_set);
	modport timer (input divisor, input rx_stop, input tx_kick,
		output rx_event, output tx_start, output tx_ready_set);
endinterface

// ---- logic/ums_baud_timer.sv ----
// baud-clock tick generator and the receive/transmit delay sequencer
// assumes divisor is steady while a character is in flight
`timescale 1ns/1ps
module ums_baud_timer
	import ums_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// core side
	ums_baud_if.timer bif
);
	logic [15:0] div_cnt_reg;
	logic bclk_tick;
	logic rx_pend_reg;
	logic [4:0] tx_cnt_reg;
	logic tx_wait_reg;
	logic ctr_wait_reg;
	logic rx_event_reg;
	logic tx_start_reg;
	logic tx_ready_reg;

	assign bclk_tick = (div_cnt_reg == 16'h0000);
	assign bif.rx_event = rx_event_reg;
	assign bif.tx_start = tx_start_reg;
	assign bif.tx_ready_set = tx_ready_reg;

	// one tick every divisor aclk cycles; zero behaves as one
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			div_cnt_reg <= 16'h0000;
		else if (bclk_tick)
			div_cnt_reg <= (bif.divisor == 16'h0000) ? 16'h0000 :
				bif.divisor - 16'h0001;
		else
			div_cnt_reg <= div_cnt_reg - 16'h0001;
	end

	// receive flag lands on the first tick after the stop bit
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_pend_reg <= 1'b0;
			rx_event_reg <= 1'b0;
		end
		else
		begin
			rx_event_reg <= rx_pend_reg && bclk_tick;
			if (bif.rx_stop)
				rx_pend_reg <= 1'b1;
			else if (bclk_tick)
				rx_pend_reg <= 1'b0;
		end
	end

	// start bit after a fixed number of ticks, ready at its center
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_cnt_reg <= 5'd0;
			tx_wait_reg <= 1'b0;
			ctr_wait_reg <= 1'b0;
			tx_start_reg <= 1'b0;
			tx_ready_reg <= 1'b0;
		end
		else
		begin
			tx_start_reg <= 1'b0;
			tx_ready_reg <= 1'b0;
			if (bif.tx_kick && !tx_wait_reg && !ctr_wait_reg)
			begin
				tx_wait_reg <= 1'b1;
				tx_cnt_reg <= 5'(TX_START_BCLK - 1);
			end
			else if (bclk_tick && tx_wait_reg)
			begin
				if (tx_cnt_reg == 5'd0)
				begin
					tx_wait_reg <= 1'b0;
					tx_start_reg <= 1'b1;
					ctr_wait_reg <= 1'b1;
					tx_cnt_reg <= 5'(START_CENTER_BCLK - 1);
				end
				else
					tx_cnt_reg <= tx_cnt_reg - 5'd1;
			end
			else if (bclk_tick && ctr_wait_reg)
			begin
				if (tx_cnt_reg == 5'd0)
				begin
					ctr_wait_reg <= 1'b0;
					tx_ready_reg <= 1'b1;
				end
				else
					tx_cnt_reg <= tx_cnt_reg - 5'd1;
			end
		end
	end
endmodule

// ---- logic/ums_uart_core.sv ----
// uart register core: modem status, scratch pad, reset values, events
// assumes an AXI4-Lite master on aclk; modem pins are asynchronous
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module ums_uart_core
	import ums_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// modem inputs, active low, asynchronous
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic ring_indicator_n,
	input wire logic carrier_detect_n,
	// receive datapath handoff, same clock
	input wire logic rx_stop_done,
	input wire logic [7:0] rx_byte,
	// transmit datapath handoff
	output logic tx_start_bit,
	output logic [7:0] tx_byte,
	// serial and modem outputs
	output logic tx_out,
	output logic rts_n,
	output logic dtr_n,
	output logic reset_out,
	// legacy interrupt pin with enable, and event interrupt
	output logic int_out,
	output logic int_oe,
	output logic irq,
	// flags
	output logic receive_ready_flag,
	output logic transmit_ready_flag
);
	ums_baud_if bif ();

	logic [3:0] pin_meta_reg;
	logic [3:0] pin_sync_reg;
	logic [3:0] msr_hi;
	logic [3:0] msr_prev_reg;
	logic [3:0] delta_reg;
	logic [3:0] delta_set;
	logic started_reg;
	logic [7:0] ier_reg;
	logic [7:0] fcr_reg;
	logic [7:0] lcr_reg;
	logic [7:0] mcr_reg;
	logic [7:0] scratch_pad;
	logic [7:0] div_low_reg;
	logic [7:0] div_high_reg;
	logic [7:0] rx_hold_reg;
	logic [7:0] tx_hold_reg;
	logic [7:0] isr_now;
	logic [7:0] lsr_now;
	logic rx_ready_reg;
	logic thr_empty_reg;
	logic tsr_empty_reg;
	logic [EVT_W-1:0] evt_status_reg;
	logic [EVT_W-1:0] evt_enable_reg;
	logic [EVT_W-1:0] evt_set;
	logic aw_held_reg;
	logic w_held_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [7:0] wdata_reg;
	logic wstrb0_reg;
	logic wr_fire;
	logic rd_fire;
	logic [7:0] rd_byte;
	logic rd_hit;
	logic loop;

	function automatic logic known_addr(input logic [ADDR_W-1:0] a);
		case (a)
			ADDR_HOLDING, ADDR_IER, ADDR_ISR_FCR, ADDR_LCR, ADDR_MCR,
			ADDR_LSR, ADDR_MSR, ADDR_SCRATCH, ADDR_DIV_LOW,
			ADDR_DIV_HIGH, ADDR_EVT_STATUS, ADDR_EVT_CLEAR,
			ADDR_EVT_ENABLE:
				known_addr = 1'b1;
			default:
				known_addr = 1'b0;
		endcase
	endfunction

	function automatic logic wr_to(input logic [ADDR_W-1:0] a);
		wr_to = wr_fire && wstrb0_reg && (awaddr_reg == a);
	endfunction

	ums_baud_timer u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.bif(bif)
	);

	assign loop = mcr_reg[MCR_LOOP];
	assign bif.divisor = {div_high_reg, div_low_reg};
	assign bif.rx_stop = rx_stop_done;
	assign bif.tx_kick = wr_fire && wstrb0_reg && awaddr_reg == ADDR_HOLDING;

	// two-stage synchroniser on the modem pins
	always_ff @(posedge aclk)
	begin
		pin_meta_reg <= {carrier_detect_n, ring_indicator_n, dsr_n, cts_n};
		pin_sync_reg <= pin_meta_reg;
	end

	// upper status nibble: inverted pins, or control bits in loopback
	always_comb
	begin
		msr_hi[MI_CTS] = loop ? mcr_reg[MCR_RTS] : ~pin_sync_reg[MI_CTS];
		msr_hi[MI_DSR] = loop ? mcr_reg[MCR_DTR] : ~pin_sync_reg[MI_DSR];
		msr_hi[MI_RI] = loop ? mcr_reg[MCR_OP1] : ~pin_sync_reg[MI_RI];
		msr_hi[MI_CD] = loop ? mcr_reg[MCR_OP2] : ~pin_sync_reg[MI_CD];
	end

	// change flags; ring only flags the end of ringing
	always_comb
	begin
		delta_set = started_reg ? (msr_hi ^ msr_prev_reg) : 4'h0;
		delta_set[MI_RI] = started_reg && msr_prev_reg[MI_RI] &&
			!msr_hi[MI_RI];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			started_reg <= 1'b0;
			msr_prev_reg <= 4'h0;
			delta_reg <= 4'h0;
		end
		else
		begin
			started_reg <= 1'b1;
			msr_prev_reg <= msr_hi;
			// a change in the cycle of the read still sets its flag
			if (rd_fire && s_axi_araddr == ADDR_MSR)
				delta_reg <= delta_set;
			else
				delta_reg <= delta_reg | delta_set;
		end
	end

	// control registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ier_reg <= RST_IER;
			fcr_reg <= RST_FCR;
			lcr_reg <= RST_LCR;
			mcr_reg <= RST_MCR;
			div_low_reg <= RST_DIV;
			div_high_reg <= 8'h00;
			tx_hold_reg <= 8'h00;
		end
		else
		begin
			if (wr_to(ADDR_IER))
				ier_reg <= wdata_reg;
			if (wr_to(ADDR_ISR_FCR))
				fcr_reg <= wdata_reg;
			if (wr_to(ADDR_LCR))
				lcr_reg <= wdata_reg;
			// power-down bit only reachable with extended access
			if (wr_to(ADDR_MCR))
			begin
				mcr_reg[6:0] <= {2'b00, wdata_reg[4:0]};
				if (ier_reg[IER_EXT])
					mcr_reg[MCR_PWRDN] <= wdata_reg[MCR_PWRDN];
			end
			if (wr_to(ADDR_DIV_LOW))
				div_low_reg <= wdata_reg;
			if (wr_to(ADDR_DIV_HIGH))
				div_high_reg <= wdata_reg;
			if (wr_to(ADDR_HOLDING))
				tx_hold_reg <= wdata_reg;
		end
	end

	// scratch: reset to all ones, untouched by power-down
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			scratch_pad <= RST_SCRATCH;
		else if (wr_to(ADDR_SCRATCH))
			scratch_pad <= wdata_reg;
	end

	// receive ready and holding byte
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_ready_reg <= 1'b0;
			rx_hold_reg <= 8'h00;
		end
		else
		begin
			if (rx_stop_done)
				rx_hold_reg <= rx_byte;
			if (bif.rx_event)
				rx_ready_reg <= 1'b1;
			else if (rd_fire && s_axi_araddr == ADDR_HOLDING)
				rx_ready_reg <= 1'b0;
		end
	end

	// transmit holding and shifter empty flags
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			thr_empty_reg <= 1'b1;
			tsr_empty_reg <= 1'b1;
		end
		else
		begin
			if (wr_to(ADDR_HOLDING))
				thr_empty_reg <= 1'b0;
			else if (bif.tx_ready_set)
				thr_empty_reg <= 1'b1;
			if (wr_to(ADDR_HOLDING))
				tsr_empty_reg <= 1'b0;
			else if (bif.tx_ready_set)
				tsr_empty_reg <= 1'b1;
		end
	end

	// interrupt source priority: receive, transmit, modem
	always_comb
	begin
		lsr_now = 8'h00;
		lsr_now[LSR_DR] = rx_ready_reg;
		lsr_now[LSR_THRE] = thr_empty_reg;
		lsr_now[LSR_TEMT] = tsr_empty_reg;
		if (ier_reg[IER_RX] && rx_ready_reg)
			isr_now = ISR_RX;
		else if (ier_reg[IER_TX] && thr_empty_reg)
			isr_now = ISR_TX;
		else if (ier_reg[IER_MODEM] && |delta_reg)
			isr_now = ISR_MODEM;
		else
			isr_now = ISR_NONE;
	end

	// sticky events, set wins over clear
	always_comb
	begin
		evt_set = '0;
		evt_set[EVT_MODEM] = |delta_set;
		evt_set[EVT_RX] = bif.rx_event;
		evt_set[EVT_TX] = bif.tx_ready_set;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			evt_status_reg <= '0;
			evt_enable_reg <= '0;
		end
		else
		begin
			if (wr_to(ADDR_EVT_CLEAR))
				evt_status_reg <= (evt_status_reg & ~wdata_reg[EVT_W-1:0]) |
					evt_set;
			else
				evt_status_reg <= evt_status_reg | evt_set;
			if (wr_to(ADDR_EVT_ENABLE))
				evt_enable_reg <= wdata_reg[EVT_W-1:0];
		end
	end

	// pins and flags, all registered
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_out <= 1'b1;
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
			reset_out <= 1'b1;
			int_out <= 1'b0;
			int_oe <= 1'b0;
			irq <= 1'b0;
			tx_start_bit <= 1'b0;
			tx_byte <= 8'h00;
			receive_ready_flag <= 1'b0;
			transmit_ready_flag <= 1'b0;
		end
		else
		begin
			tx_out <= loop | ~lcr_reg[LCR_BREAK];
			rts_n <= loop | ~mcr_reg[MCR_RTS];
			dtr_n <= loop | ~mcr_reg[MCR_DTR];
			reset_out <= ier_reg[IER_EXT] & mcr_reg[MCR_OP1];
			int_out <= ~isr_now[0];
			int_oe <= ~loop & mcr_reg[MCR_OP2];
			irq <= |(evt_status_reg & evt_enable_reg);
			tx_start_bit <= bif.tx_start;
			tx_byte <= tx_hold_reg;
			receive_ready_flag <= rx_ready_reg;
			transmit_ready_flag <= thr_empty_reg;
		end
	end

	// axi write: address and data taken in either order
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready = !w_held_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && !aw_held_reg)
			begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held_reg)
			begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
			end
			if (wr_fire)
			begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= known_addr(awaddr_reg) ? RESP_OKAY :
					RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// axi read mux
	always_comb
	begin
		rd_hit = known_addr(s_axi_araddr);
		case (s_axi_araddr)
			ADDR_HOLDING:
				rd_byte = rx_hold_reg;
			ADDR_IER:
				rd_byte = ier_reg;
			ADDR_ISR_FCR:
				rd_byte = isr_now;
			ADDR_LCR:
				rd_byte = lcr_reg;
			ADDR_MCR:
				rd_byte = mcr_reg;
			ADDR_LSR:
				rd_byte = lsr_now;
			ADDR_MSR:
				rd_byte = {msr_hi, delta_reg};
			ADDR_SCRATCH:
				rd_byte = scratch_pad;
			ADDR_DIV_LOW:
				rd_byte = div_low_reg;
			ADDR_DIV_HIGH:
				rd_byte = div_high_reg;
			ADDR_EVT_STATUS:
				rd_byte = {5'b00000, evt_status_reg};
			ADDR_EVT_ENABLE:
				rd_byte = {5'b00000, evt_enable_reg};
			default:
				rd_byte = 8'h00;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire = s_axi_arvalid && !s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h00_0000, rd_byte};
			s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule

// ---- test/ums_core_properties.sv ----
// port assertions of the uart register core
// assumes divisor stays at its reset value of one
`timescale 1ns/1ps
module ums_core_properties (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// datapath handoff and pins
	input wire logic rx_stop_done,
	input wire logic tx_start_bit,
	input wire logic tx_out,
	input wire logic rts_n,
	input wire logic dtr_n,
	input wire logic reset_out,
	input wire logic int_oe,
	input wire logic receive_ready_flag,
	input wire logic transmit_ready_flag
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	reset_outputs_a: assert property (
		$rose(aresetn) |-> tx_out && rts_n && dtr_n && reset_out && !int_oe)
		else $error("pin levels wrong after reset");
	write_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write response late");
	read_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
		s_axi_rdata[31:8] == 24'h00_0000) else $error("read answer wrong");
	read_holds_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	write_holds_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	resp_release_a: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not released");
	start_pulse_a: assert property (
		tx_start_bit |=> !tx_start_bit) else $error("start pulse too long");
	tx_ready_a: assert property (
		tx_start_bit |-> ##[1:12] transmit_ready_flag)
		else $error("transmit ready late");
	rx_ready_a: assert property (
		rx_stop_done |-> ##[1:4] receive_ready_flag)
		else $error("receive ready late");
endmodule

// ---- test/ums_modem_peer.sv ----
// model of the modem and the receive datapath facing the core
// assumes bench commands change right after a rising edge
`timescale 1ns/1ps
module ums_modem_peer (
	// clock
	input wire logic aclk,
	// bench commands
	input wire logic [3:0] pin_cmd,
	input wire logic send_char,
	input wire logic [7:0] char_cmd,
	input wire logic power_down,
	// modem lines, active low
	output logic cts_n,
	output logic dsr_n,
	output logic ring_indicator_n,
	output logic carrier_detect_n,
	// end of received character
	output logic rx_stop_done,
	output logic [7:0] rx_byte
);
	initial
	begin
		{carrier_detect_n, ring_indicator_n, dsr_n, cts_n} = 4'hf;
		rx_stop_done = 1'b0;
		rx_byte = 8'h00;
	end
	always @(posedge aclk)
	begin
		{carrier_detect_n, ring_indicator_n, dsr_n, cts_n} <= pin_cmd;
		// line stays idle while the core sleeps
		rx_stop_done <= send_char && !power_down;
		// byte only valid with the pulse
		rx_byte <= send_char ? char_cmd : ~rx_byte;
	end
endmodule

// ---- test/ums_uart_core_test.sv ----
// self-checking bench of the uart register core
// assumes one aclk for core and peer; divisor stays at one
`timescale 1ns/1ps
module ums_uart_core_test
	import ums_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0;
	logic [ADDR_W-1:0] s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, tx_start_bit, tx_out, rts_n, dtr_n, reset_out;
	logic int_out, int_oe, irq, receive_ready_flag, transmit_ready_flag;
	logic cts_n, dsr_n, ring_indicator_n, carrier_detect_n, rx_stop_done;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata;
	logic [7:0] rx_byte, tx_byte, rd, wr;
	logic [3:0] pin_cmd = 4'h5;
	logic [3:0] prev;
	logic send_char = 1'b0;
	logic [7:0] char_cmd = 8'h00;
	logic power_down = 1'b0;
	logic [31:0] seed = 32'h0000_539e;
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;
	int n;

	ums_uart_core u_ums_uart_core (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cts_n,
		.dsr_n, .ring_indicator_n, .carrier_detect_n, .rx_stop_done,
		.rx_byte, .tx_start_bit, .tx_byte, .tx_out, .rts_n, .dtr_n,
		.reset_out, .int_out, .int_oe, .irq, .receive_ready_flag,
		.transmit_ready_flag);
	ums_modem_peer u_ums_modem_peer (.aclk, .pin_cmd, .send_char,
		.char_cmd, .power_down, .cts_n, .dsr_n, .ring_indicator_n,
		.carrier_detect_n, .rx_stop_done, .rx_byte);

	always #2.5 aclk = ~aclk;
	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			mismatches = mismatches + 1;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// change flags: any edge, ring only on release
	function automatic logic [3:0] delta(input logic [3:0] o, v);
		return {o[3] ^ v[3], !o[2] && v[2], o[1] ^ v[1], o[0] ^ v[0]};
	endfunction
	task automatic check(input string what, input logic [7:0] exp, got);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge aclk);
		#1;
	endtask
	task automatic wr_reg(input logic [7:0] a, d);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done)
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				resp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	task automatic rd_reg(input logic [7:0] a);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done)
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				rd = s_axi_rdata[7:0];
				resp = s_axi_rresp;
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, exp);
		rd_reg(a);
		check(what, exp, rd);
	endtask

	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk("ier", ADDR_IER, 8'h00);
		rd_chk("isr", ADDR_ISR_FCR, 8'h01);
		rd_chk("lcr", ADDR_LCR, 8'h00);
		rd_chk("mcr", ADDR_MCR, 8'h00);
		rd_chk("lsr", ADDR_LSR, 8'h60);
		rd_chk("msr", ADDR_MSR, {~pin_cmd, 4'h0});
		rd_chk("scratch", ADDR_SCRATCH, 8'hff);
		wr_reg(8'h3c, 8'h55);
		check("bresp", {6'h00, RESP_SLVERR}, {6'h00, resp});
		rd_chk("unmapped", 8'h3c, 8'h00);
		check("rresp", {6'h00, RESP_SLVERR}, {6'h00, resp});
		$display("reset test done");
		for (int i = 0; i < 6; i++)
		begin
			wr = (i == 0) ? 8'h00 : 8'(rnd());
			wr_reg(ADDR_SCRATCH, wr);
			rd_chk("scratch", ADDR_SCRATCH, wr);
		end
		rd_chk("lcr", ADDR_LCR, 8'h00);
		$display("scratch test done");
		wr_reg(ADDR_EVT_ENABLE, 8'h01);
		for (int i = 0; i < 10; i++)
		begin
			prev = pin_cmd;
			@(posedge aclk);
			pin_cmd <= (i == 0) ? ~prev : 4'(rnd());
			tick(8);
			check("irq", {7'h00, delta(prev, pin_cmd) != 4'h0}, {7'h00, irq});
			rd_chk("msr", ADDR_MSR, {~pin_cmd, delta(prev, pin_cmd)});
			rd_chk("msr reread", ADDR_MSR, {~pin_cmd, 4'h0});
			wr_reg(ADDR_EVT_CLEAR, 8'h07);
		end
		wr_reg(ADDR_EVT_ENABLE, 8'h00);
		@(posedge aclk);
		pin_cmd <= ~pin_cmd;
		tick(8);
		check("masked irq", 8'h00, {7'h00, irq});
		rd_chk("event status", ADDR_EVT_STATUS, 8'h01);
		$display("modem test done");
		for (int i = 0; i < 5; i++)
		begin
			wr = {4'h1, (i == 0) ? 4'hf : 4'(rnd())};
			wr_reg(ADDR_MCR, wr);
			tick(3);
			rd_reg(ADDR_MSR);
			prev = {wr[3:2], wr[0], wr[1]};
			check("loop msr", {prev, 4'h0}, {rd[7:4], 4'h0});
		end
		wr_reg(ADDR_MCR, 8'h00);
		wr_reg(ADDR_EVT_CLEAR, 8'h07);
		wr_reg(ADDR_EVT_ENABLE, 8'h02);
		$display("loopback test done");
		for (int i = 0; i < 3; i++)
		begin
			wr = 8'(rnd());
			@(posedge aclk);
			send_char <= 1'b1;
			char_cmd <= wr;
			@(posedge aclk);
			send_char <= 1'b0;
			tick(6);
			check("rx ready", 8'h01, {7'h00, receive_ready_flag});
			check("rx irq", 8'h01, {7'h00, irq});
			rd_chk("holding", ADDR_HOLDING, wr);
			tick(2);
			check("rx ready off", 8'h00, {7'h00, receive_ready_flag});
			wr_reg(ADDR_EVT_CLEAR, 8'h02);
		end
		$display("receive test done");
		wr_reg(ADDR_EVT_ENABLE, 8'h04);
		wr = 8'(rnd());
		wr_reg(ADDR_HOLDING, wr);
		n = 0;
		while (!tx_start_bit && n < 40)
		begin
			@(posedge aclk);
			n++;
		end
		check("tx busy", 8'h00, {7'h00, transmit_ready_flag});
		check("start delay", 8'h01, {7'h00, n >= 8 && n <= 24});
		check("tx byte", wr, tx_byte);
		tick(12);
		check("tx ready", 8'h01, {7'h00, transmit_ready_flag});
		check("tx irq", 8'h01, {7'h00, irq});
		$display("transmit test done");
		wr_reg(ADDR_IER, 8'h22);
		wr_reg(ADDR_MCR, 8'h8b);
		power_down <= 1'b1;
		wr_reg(ADDR_SCRATCH, 8'h5a);
		rd_chk("mcr", ADDR_MCR, 8'h8b);
		rd_chk("sleep scratch", ADDR_SCRATCH, 8'h5a);
		check("int pin", 8'h03, {6'h00, int_oe, int_out});
		wr_reg(ADDR_LCR, 8'h40);
		tick(1);
		check("pins awake", 8'h00, {4'h0, tx_out, rts_n, dtr_n, reset_out});
		@(posedge aclk);
		aresetn <= 1'b0;
		tick(3);
		check("reset pins", 8'h0f, {4'h0, tx_out, rts_n, dtr_n, reset_out});
		check("int enable", 8'h00, {7'h00, int_oe});
		repeat (17) @(posedge aclk);
		aresetn <= 1'b1;
		power_down <= 1'b0;
		rd_chk("scratch", ADDR_SCRATCH, 8'hff);
		rd_chk("mcr", ADDR_MCR, 8'h00);
		rd_chk("lcr", ADDR_LCR, 8'h00);
		$display("second reset test done");
		final_report();
	end
endmodule

bind ums_uart_core ums_core_properties u_ums_core_properties (.aclk,
	.aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .rx_stop_done, .tx_start_bit, .tx_out, .rts_n, .dtr_n,
	.reset_out, .int_oe, .receive_ready_flag, .transmit_ready_flag);
